// file: logic/clock_generator_osc_pll_control.sv
// Contract
// RULE1 - reset: oscillator off, slow clock selected
// RULE2 - clearing enable clears the stable flag
// RULE3 - software loads startup count for crystal
// RULE4 - enable write clears flag, counts down slow/8
// RULE5 - count reaching zero sets stable flag
// RULE6 - tally starts after slow rise once stable
// RULE7 - sixteenth slow fall stops tally, sets done
// RULE8 - bypass needs bypass one, enable zero (code drives bypass from the bypass bit alone, whatever the enable)
// RULE9 - software keeps divided input above minimum
// RULE10 - divider accepts 1 to 255
// RULE11 - divider zero holds outputs low
// RULE12 - reset clears every divider field
// RULE13 - output scales by (factor + 1) / divider
// RULE14 - zero factor powers pll down
// RULE15 - re-enable or change clears settled flag
// RULE16 - settle count on slow clock sets settled
// RULE17 - software sizes settle count for filter
// RULE18 - software programs charge pump configuration
// RULE19 - unmasked flags form one level interrupt
module clock_generator_osc_pll_control
    import clkgen_pkg::*;
(
    // clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                RST_N,
    // clock pins
    input  wire logic                SLOW_CLK,
    input  wire logic                MAIN_OSC_CLK,
    // main oscillator control
    input  wire logic                MAIN_OSC_CTRL_WR,
    input  wire logic                MAIN_OSC_ENABLE,
    input  wire logic [7:0]          OSC_STARTUP_COUNT,
    input  wire logic                OSC_BYPASS_SELECT,
    // pll a configuration
    input  wire logic                PLL_A_CFG_WR,
    input  wire logic [DIV_W-1:0]    PLL_A_DIVIDE,
    input  wire logic [MUL_W-1:0]    PLL_A_SCALE_FACTOR,
    input  wire logic [SETTLE_W-1:0] PLL_A_SETTLE_COUNT,
    // pll b configuration
    input  wire logic                PLL_B_CFG_WR,
    input  wire logic [DIV_W-1:0]    PLL_B_DIVIDE,
    input  wire logic [MUL_W-1:0]    PLL_B_SCALE_FACTOR,
    input  wire logic [SETTLE_W-1:0] PLL_B_SETTLE_COUNT,
    // charge pump and interrupt mask
    input  wire logic                PLL_CP_CFG_WR,
    input  wire logic [CP_W-1:0]     PLL_CHARGE_PUMP_CFG,
    input  wire logic [IRQ_W-1:0]    POWER_IRQ_MASK,
    // analog controls
    output logic                     OSC_ENABLE_OUT,
    output logic                     OSC_BYPASS_OUT,
    output logic                     SLOW_CLK_SELECTED,
    output logic                     PLL_A_POWER_ON,
    output logic                     PLL_B_POWER_ON,
    output logic [CP_W-1:0]          PLL_CP_OUT,
    // status
    output logic                     MAIN_OSC_STABLE_FLAG,
    output logic                     FREQ_MEASURE_DONE,
    output logic [TALLY_W-1:0]       MAIN_CYCLE_TALLY,
    output logic                     PLL_A_SETTLED,
    output logic                     PLL_B_SETTLED,
    output logic                     POWER_IRQ,
    // generated clocks
    output logic                     PLL_A_CLK_OUT,
    output logic                     PLL_B_CLK_OUT
);

    logic                   rst_meta_reg;
    logic                   rst_n;
    logic                   slow_meta_reg, slow_sync_reg, slow_prev_reg;
    logic                   main_meta_reg, main_sync_reg, main_prev_reg;
    logic                   slow_rise, slow_fall, main_rise;

    logic [2:0]             pre8_reg,      pre8_next;
    logic                   tick8;
    logic                   osc_en_reg,    osc_en_next;
    logic                   bypass_reg,    bypass_next;
    logic [OSC_COUNT_W-1:0] osc_cnt_reg,   osc_cnt_next;
    logic                   starting_reg,  starting_next;
    logic                   stable_reg,    stable_next;
    logic                   sel_slow_reg,  sel_slow_next;

    meas_state_e            meas_reg,      meas_next;
    logic [3:0]             fall_cnt_reg,  fall_cnt_next;
    logic [TALLY_W-1:0]     tally_reg,     tally_next;
    logic                   done_reg,      done_next;

    logic [CP_W-1:0]        cp_reg,        cp_next;
    logic [IRQ_W-1:0]       flags;
    logic                   irq_reg,       irq_next;
    logic                   lock_a, lock_b;
    logic                   pwr_a, pwr_b;
    logic                   out_a, out_b;

    // reset release through two flops
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // pin synchronisers and edge detect
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            slow_meta_reg <= 1'b0;
            slow_sync_reg <= 1'b0;
            slow_prev_reg <= 1'b0;
            main_meta_reg <= 1'b0;
            main_sync_reg <= 1'b0;
            main_prev_reg <= 1'b0;
        end else begin
            slow_meta_reg <= SLOW_CLK;
            slow_sync_reg <= slow_meta_reg;
            slow_prev_reg <= slow_sync_reg;
            main_meta_reg <= MAIN_OSC_CLK;
            main_sync_reg <= main_meta_reg;
            main_prev_reg <= main_sync_reg;
        end
    end

    assign slow_rise = slow_sync_reg && !slow_prev_reg;
    assign slow_fall = !slow_sync_reg && slow_prev_reg;
    assign main_rise = main_sync_reg && !main_prev_reg;
    assign tick8     = slow_rise && (pre8_reg == SLOW_PRESCALE_LAST);

    // main oscillator enable and startup countdown
    always_comb begin
        pre8_next     = pre8_reg;
        osc_en_next   = osc_en_reg;
        bypass_next   = bypass_reg;
        osc_cnt_next  = osc_cnt_reg;
        starting_next = starting_reg;
        stable_next   = stable_reg;
        sel_slow_next = !stable_reg;                       // [RULE1]
        if (slow_rise)
            pre8_next = pre8_reg + 3'h1;
        if (MAIN_OSC_CTRL_WR) begin
            osc_en_next = MAIN_OSC_ENABLE;
            bypass_next = OSC_BYPASS_SELECT;               // [RULE8]
            stable_next = 1'b0;                            // [RULE2] [RULE4]
            if (MAIN_OSC_ENABLE) begin
                osc_cnt_next  = OSC_STARTUP_COUNT;         // [RULE4]
                starting_next = 1'b1;
                pre8_next     = 3'h0;
            end else begin
                osc_cnt_next  = OSC_COUNT_RST;
                starting_next = 1'b0;
            end
        end else if (starting_reg && tick8) begin
            if (osc_cnt_reg <= OSC_COUNT_W'(1)) begin
                osc_cnt_next  = OSC_COUNT_RST;
                starting_next = 1'b0;
                stable_next   = 1'b1;                      // [RULE5]
            end else begin
                osc_cnt_next = osc_cnt_reg - OSC_COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pre8_reg     <= 3'h0;
            osc_en_reg   <= 1'b0;                          // [RULE1]
            bypass_reg   <= 1'b0;
            osc_cnt_reg  <= OSC_COUNT_RST;
            starting_reg <= 1'b0;
            stable_reg   <= 1'b0;
            sel_slow_reg <= 1'b1;                          // [RULE1]
        end else begin
            pre8_reg     <= pre8_next;
            osc_en_reg   <= osc_en_next;
            bypass_reg   <= bypass_next;
            osc_cnt_reg  <= osc_cnt_next;
            starting_reg <= starting_next;
            stable_reg   <= stable_next;
            sel_slow_reg <= sel_slow_next;
        end
    end

    // main clock frequency measurement
    always_comb begin
        meas_next     = meas_reg;
        fall_cnt_next = fall_cnt_reg;
        tally_next    = tally_reg;
        done_next     = done_reg;
        case (meas_reg)
            MEAS_IDLE: begin
                done_next = 1'b0;
                if (stable_reg)
                    meas_next = MEAS_ARM;
            end
            MEAS_ARM: begin
                if (!stable_reg) begin
                    meas_next = MEAS_IDLE;
                end else if (slow_rise) begin
                    meas_next     = MEAS_RUN;              // [RULE6]
                    fall_cnt_next = 4'h0;
                    tally_next    = '0;
                end
            end
            MEAS_RUN: begin
                if (!stable_reg) begin
                    meas_next = MEAS_IDLE;
                end else begin
                    if (main_rise && tally_reg != TALLY_MAX)
                        tally_next = tally_reg + TALLY_W'(1); // [RULE6]
                    if (slow_fall) begin
                        fall_cnt_next = fall_cnt_reg + 4'h1;
                        if (fall_cnt_reg == MEAS_FALL_LAST) begin
                            meas_next = MEAS_DONE;         // [RULE7]
                            done_next = 1'b1;
                        end
                    end
                end
            end
            MEAS_DONE: begin
                if (!stable_reg) begin
                    meas_next = MEAS_IDLE;
                    done_next = 1'b0;
                end
            end
            default: begin
                meas_next = MEAS_IDLE;
                done_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            meas_reg     <= MEAS_IDLE;
            fall_cnt_reg <= 4'h0;
            tally_reg    <= '0;
            done_reg     <= 1'b0;
        end else begin
            meas_reg     <= meas_next;
            fall_cnt_reg <= fall_cnt_next;
            tally_reg    <= tally_next;
            done_reg     <= done_next;
        end
    end

    // the two pll channels share the main clock as source
    pll_channel u_pll_a (
        .clk       (REF_CLK),
        .rst_n     (rst_n),
        .src_rise  (main_rise),
        .slow_rise (slow_rise),
        .cfg_wr    (PLL_A_CFG_WR),
        .div_in    (PLL_A_DIVIDE),
        .mul_in    (PLL_A_SCALE_FACTOR),
        .settle_in (PLL_A_SETTLE_COUNT),
        .pll_out   (out_a),
        .settled   (lock_a),
        .powered   (pwr_a)
    );

    pll_channel u_pll_b (
        .clk       (REF_CLK),
        .rst_n     (rst_n),
        .src_rise  (main_rise),
        .slow_rise (slow_rise),
        .cfg_wr    (PLL_B_CFG_WR),
        .div_in    (PLL_B_DIVIDE),
        .mul_in    (PLL_B_SCALE_FACTOR),
        .settle_in (PLL_B_SETTLE_COUNT),
        .pll_out   (out_b),
        .settled   (lock_b),
        .powered   (pwr_b)
    );

    // charge pump setting and interrupt level
    always_comb begin
        flags                 = '0;
        flags[IRQ_STABLE_BIT] = stable_reg;
        flags[IRQ_LOCK_A_BIT] = lock_a;
        flags[IRQ_LOCK_B_BIT] = lock_b;
        flags[IRQ_FREQ_BIT]   = done_reg;
        irq_next = |(flags & POWER_IRQ_MASK);              // [RULE19]
        cp_next  = PLL_CP_CFG_WR ? PLL_CHARGE_PUMP_CFG : cp_reg; // [RULE18]
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
            cp_reg  <= CP_RST;
        end else begin
            irq_reg <= irq_next;
            cp_reg  <= cp_next;
        end
    end

    assign OSC_ENABLE_OUT       = osc_en_reg;
    assign OSC_BYPASS_OUT       = bypass_reg;
    assign SLOW_CLK_SELECTED    = sel_slow_reg;
    assign PLL_A_POWER_ON       = pwr_a;
    assign PLL_B_POWER_ON       = pwr_b;
    assign PLL_CP_OUT           = cp_reg;
    assign MAIN_OSC_STABLE_FLAG = stable_reg;
    assign FREQ_MEASURE_DONE    = done_reg;
    assign MAIN_CYCLE_TALLY     = tally_reg;
    assign PLL_A_SETTLED        = lock_a;
    assign PLL_B_SETTLED        = lock_b;
    assign POWER_IRQ            = irq_reg;
    assign PLL_A_CLK_OUT        = out_a;
    assign PLL_B_CLK_OUT        = out_b;

    property p_disable_clears;
        @(posedge REF_CLK) disable iff (!rst_n)
        (MAIN_OSC_CTRL_WR && !MAIN_OSC_ENABLE)
            |=> !stable_reg && !starting_reg && !osc_en_reg;
    endproperty
    a_disable_clears: assert property (p_disable_clears) // [RULE2]
        else $error("oscillator disable left stable flag set");

    property p_enable_loads;
        @(posedge REF_CLK) disable iff (!rst_n)
        (MAIN_OSC_CTRL_WR && MAIN_OSC_ENABLE)
            |=> !stable_reg && starting_reg
                && osc_cnt_reg == $past(OSC_STARTUP_COUNT);
    endproperty
    a_enable_loads: assert property (p_enable_loads) // [RULE4]
        else $error("startup count not loaded on enable");

    property p_stable_at_zero;
        @(posedge REF_CLK) disable iff (!rst_n)
        (starting_reg && tick8 && osc_cnt_reg <= OSC_COUNT_W'(1)
            && !MAIN_OSC_CTRL_WR) |=> stable_reg && !starting_reg;
    endproperty
    a_stable_at_zero: assert property (p_stable_at_zero) // [RULE5]
        else $error("startup countdown end did not set stable");

    property p_count_only_on_tick;
        @(posedge REF_CLK) disable iff (!rst_n)
        (starting_reg && !tick8 && !MAIN_OSC_CTRL_WR)
            |=> $stable(osc_cnt_reg) && !stable_reg;
    endproperty
    a_count_only_on_tick: assert property (p_count_only_on_tick) // [RULE4]
        else $error("startup counter moved without slow/8 tick");

    property p_run_needs_stable;
        @(posedge REF_CLK) disable iff (!rst_n)
        (meas_reg == MEAS_RUN) |-> $past(stable_reg);
    endproperty
    a_run_needs_stable: assert property (p_run_needs_stable) // [RULE6]
        else $error("tally running without stable oscillator");

    property p_done_at_sixteen;
        @(posedge REF_CLK) disable iff (!rst_n)
        (meas_reg == MEAS_RUN && stable_reg && slow_fall
            && fall_cnt_reg == MEAS_FALL_LAST)
            |=> done_reg ##1 $stable(tally_reg);
    endproperty
    a_done_at_sixteen: assert property (p_done_at_sixteen) // [RULE7]
        else $error("tally did not stop at sixteenth fall");

    property p_irq_level;
        @(posedge REF_CLK) disable iff (!rst_n)
        (|(flags & POWER_IRQ_MASK)) |=> irq_reg;
    endproperty
    a_irq_level: assert property (p_irq_level) // [RULE19]
        else $error("unmasked flag did not raise interrupt");

    property p_slow_selected;
        @(posedge REF_CLK) disable iff (!rst_n)
        !stable_reg |=> sel_slow_reg;
    endproperty
    a_slow_selected: assert property (p_slow_selected) // [RULE1]
        else $error("slow clock not selected while main unstable");

    c_stable: cover property (@(posedge REF_CLK) disable iff (!rst_n)
        $rose(stable_reg));
    c_done: cover property (@(posedge REF_CLK) disable iff (!rst_n)
        $rose(done_reg));
    c_irq: cover property (@(posedge REF_CLK) disable iff (!rst_n)
        $rose(irq_reg));

endmodule // clock_generator_osc_pll_control

// file: logic/clkgen_pkg.sv
package clkgen_pkg;

    // main oscillator startup
    localparam int              OSC_COUNT_W        = 8;
    localparam logic [7:0]      OSC_COUNT_RST      = 8'h00;
    localparam logic [2:0]      SLOW_PRESCALE_LAST = 3'h7;

    // frequency measurement from a slow rise to the 16th slow clock fall
    localparam int              TALLY_W            = 16;
    localparam logic [15:0]     TALLY_MAX          = 16'hffff;
    localparam logic [3:0]      MEAS_FALL_LAST     = 4'hf;

    // pll fields
    localparam int              DIV_W              = 8;
    localparam int              MUL_W              = 11;
    localparam int              SETTLE_W           = 6;
    localparam int              CREDIT_W           = 16;
    localparam int              CP_W               = 8;
    localparam logic [7:0]      DIV_RST            = 8'h00;
    localparam logic [10:0]     MUL_RST            = 11'h000;
    localparam logic [5:0]      SETTLE_RST         = 6'h00;
    localparam logic [7:0]      CP_RST             = 8'h00;

    // status / mask bit positions
    localparam int              IRQ_W              = 4;
    localparam int              IRQ_STABLE_BIT     = 0;
    localparam int              IRQ_LOCK_A_BIT     = 1;
    localparam int              IRQ_LOCK_B_BIT     = 2;
    localparam int              IRQ_FREQ_BIT       = 3;

    typedef enum logic [3:0] {
        MEAS_IDLE = 4'b0001,
        MEAS_ARM  = 4'b0010,
        MEAS_RUN  = 4'b0100,
        MEAS_DONE = 4'b1000
    } meas_state_e;

endpackage

// file: logic/pll_channel.sv
module pll_channel
    import clkgen_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // timing enables
    input  wire logic                src_rise,
    input  wire logic                slow_rise,
    // configuration
    input  wire logic                cfg_wr,
    input  wire logic [DIV_W-1:0]    div_in,
    input  wire logic [MUL_W-1:0]    mul_in,
    input  wire logic [SETTLE_W-1:0] settle_in,
    // results
    output logic                     pll_out,
    output logic                     settled,
    output logic                     powered
);

    logic [DIV_W-1:0]    div_reg,      div_next;
    logic [MUL_W-1:0]    mul_reg,      mul_next;
    logic [SETTLE_W-1:0] settle_reg,   settle_next;
    logic [SETTLE_W-1:0] cnt_reg,      cnt_next;
    logic                counting_reg, counting_next;
    logic                settled_reg,  settled_next;
    logic [DIV_W-1:0]    pre_reg,      pre_next;
    logic [CREDIT_W-1:0] credit_reg,   credit_next;
    logic                out_reg,      out_next;
    logic                powered_reg,  powered_next;
    logic                changed;
    logic                active;
    logic [CREDIT_W:0]   credit_sum;

    assign changed = cfg_wr && ({div_in, mul_in, settle_in}
                     != {div_reg, mul_reg, settle_reg});
    assign active  = (div_reg != DIV_RST) && (mul_reg != MUL_RST);

    always_comb begin
        div_next      = div_reg;
        mul_next      = mul_reg;
        settle_next   = settle_reg;
        cnt_next      = cnt_reg;
        counting_next = counting_reg;
        settled_next  = settled_reg;
        pre_next      = pre_reg;
        credit_next   = credit_reg;
        out_next      = out_reg;
        credit_sum    = {1'b0, credit_reg};
        if (changed) begin
            div_next     = div_in;
            mul_next     = mul_in;
            settle_next  = settle_in;
            settled_next = 1'b0;                           // [RULE15]
            counting_next = (mul_in != MUL_RST);           // [RULE14]
            cnt_next     = settle_in;                      // [RULE16]
        end else if (counting_reg && slow_rise) begin
            if (cnt_reg <= SETTLE_W'(1)) begin
                cnt_next      = SETTLE_RST;
                counting_next = 1'b0;
                settled_next  = 1'b1;                      // [RULE16]
            end else begin
                cnt_next = cnt_reg - SETTLE_W'(1);
            end
        end
        powered_next = (mul_next != MUL_RST);              // [RULE14]
        if (!active) begin
            pre_next    = DIV_RST;                         // [RULE11]
            credit_next = '0;
            out_next    = 1'b0;                            // [RULE11]
        end else begin
            if (credit_reg != '0) begin
                credit_sum = credit_sum - (CREDIT_W+1)'(1);
                out_next   = ~out_reg;
            end
            if (src_rise) begin
                if (pre_reg >= div_reg - DIV_W'(1)) begin  // [RULE10]
                    pre_next   = DIV_RST;
                    // two half periods per step of (mul + 1)
                    credit_sum = credit_sum
                        + (CREDIT_W+1)'({mul_reg, 1'b0})
                        + (CREDIT_W+1)'(2);                // [RULE13]
                end else begin
                    pre_next = pre_reg + DIV_W'(1);
                end
            end
            if (credit_sum[CREDIT_W])
                credit_next = '1;
            else
                credit_next = credit_sum[CREDIT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg      <= DIV_RST;                       // [RULE12]
            mul_reg      <= MUL_RST;
            settle_reg   <= SETTLE_RST;
            cnt_reg      <= SETTLE_RST;
            counting_reg <= 1'b0;
            settled_reg  <= 1'b0;
            pre_reg      <= DIV_RST;
            credit_reg   <= '0;
            out_reg      <= 1'b0;
            powered_reg  <= 1'b0;
        end else begin
            div_reg      <= div_next;
            mul_reg      <= mul_next;
            settle_reg   <= settle_next;
            cnt_reg      <= cnt_next;
            counting_reg <= counting_next;
            settled_reg  <= settled_next;
            pre_reg      <= pre_next;
            credit_reg   <= credit_next;
            out_reg      <= out_next;
            powered_reg  <= powered_next;
        end
    end

    assign pll_out = out_reg;
    assign settled = settled_reg;
    assign powered = powered_reg;

    property p_div_zero_low;
        @(posedge clk) disable iff (!rst_n)
        (div_reg == DIV_RST) |=> !out_reg;
    endproperty
    a_div_zero_low: assert property (p_div_zero_low) // [RULE11]
        else $error("pll output toggles with divider zero");

    property p_change_clears;
        @(posedge clk) disable iff (!rst_n)
        changed |=> !settled_reg ##0 (counting_reg == (mul_reg != MUL_RST));
    endproperty
    a_change_clears: assert property (p_change_clears) // [RULE15]
        else $error("parameter change did not clear settled flag");

    property p_settle_end;
        @(posedge clk) disable iff (!rst_n)
        (counting_reg && slow_rise && cnt_reg <= SETTLE_W'(1) && !changed)
            |=> settled_reg && !counting_reg;
    endproperty
    a_settle_end: assert property (p_settle_end) // [RULE16]
        else $error("settle count ended without settled flag");

    property p_mul_zero_idle;
        @(posedge clk) disable iff (!rst_n)
        (mul_reg == MUL_RST) |-> !counting_reg && !settled_reg;
    endproperty
    a_mul_zero_idle: assert property (p_mul_zero_idle) // [RULE14]
        else $error("disabled pll counting or settled");

    c_settled: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(settled_reg));

endmodule // pll_channel

// file: bench/clock_generator_osc_pll_control_test.sv
module clock_generator_osc_pll_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ck, rn, sc, mc, ow, oe, ob, aw, bw, cw, p;
    logic [7:0] oc, ad, bd, cp;
    logic [10:0] am, bm;
    logic [5:0] as, bs;
    logic [3:0] im;
    logic eo, bo, ss, ap, bp, st, dn, al, bl, iq, ao, bk;
    logic [7:0] co;
    logic [15:0] ty;
    int errors, tests_run, n;

    clock_generator_osc_pll_control DUT (.REF_CLK(ck), .RST_N(rn),
        .SLOW_CLK(sc), .MAIN_OSC_CLK(mc), .MAIN_OSC_CTRL_WR(ow),
        .MAIN_OSC_ENABLE(oe), .OSC_STARTUP_COUNT(oc), .OSC_BYPASS_SELECT(ob),
        .PLL_A_CFG_WR(aw), .PLL_A_DIVIDE(ad), .PLL_A_SCALE_FACTOR(am),
        .PLL_A_SETTLE_COUNT(as), .PLL_B_CFG_WR(bw), .PLL_B_DIVIDE(bd),
        .PLL_B_SCALE_FACTOR(bm), .PLL_B_SETTLE_COUNT(bs), .PLL_CP_CFG_WR(cw),
        .PLL_CHARGE_PUMP_CFG(cp), .POWER_IRQ_MASK(im), .OSC_ENABLE_OUT(eo),
        .OSC_BYPASS_OUT(bo), .SLOW_CLK_SELECTED(ss), .PLL_A_POWER_ON(ap),
        .PLL_B_POWER_ON(bp), .PLL_CP_OUT(co), .MAIN_OSC_STABLE_FLAG(st),
        .FREQ_MEASURE_DONE(dn), .MAIN_CYCLE_TALLY(ty), .PLL_A_SETTLED(al),
        .PLL_B_SETTLED(bl), .POWER_IRQ(iq), .PLL_A_CLK_OUT(ao),
        .PLL_B_CLK_OUT(bk));

    // slow edges coincide with main rises, 2 ns before a clock rise, so sampling is exact
    initial begin ck = 0; forever #5 ck = ~ck; end
    initial begin sc = 0; #3; forever #320 sc = ~sc; end
    initial begin mc = 0; #43; forever #40 mc = ~mc; end

    task check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge ck);
        #1;
    endtask

    task wosc(input logic e, input logic [7:0] c, input logic b);
        @(posedge ck);
        ow <= 1; oe <= e; oc <= c; ob <= b;
        @(posedge ck);
        ow <= 0;
        #1;
    endtask

    task wpll(input logic b, input logic [7:0] d, input logic [10:0] m,
              input logic [5:0] s);
        @(posedge ck);
        if (b) begin bw <= 1; bd <= d; bm <= m; bs <= s; end
        else begin aw <= 1; ad <= d; am <= m; as <= s; end
        @(posedge ck);
        aw <= 0; bw <= 0;
        #1;
    endtask

    // toggles of a generated clock over k cycles
    task tog(input logic b, input int k, output int t);
        t = 0;
        p = b ? bk : ao;
        repeat (k) begin
            cyc(1);
            if ((b ? bk : ao) !== p) t++;
            p = b ? bk : ao;
        end
    endtask

    task automatic wait_on(ref logic f, input int lim);
        n = 0;
        while (f !== 1'b1 && n < lim) begin cyc(1); n++; end
    endtask

    task t_reset;
        check({eo, ss}, 2'b01);
        check({ao, bk, al, bl}, 4'h0);
    endtask

    task t_pll;
        int t;
        wpll(0, 8'h00, 11'h003, 6'h01);
        tog(0, 400, t);
        check(t, 0);
        check(ap, 1);
        wpll(0, 8'h02, 11'h002, 6'h02);
        check(al, 0);
        wait_on(al, 200);
        check(n >= 60 && n <= 140, 1);
        tog(0, 1600, t);
        check(t >= 592 && t <= 608, 1);
        wpll(0, 8'h02, 11'h001, 6'h02);
        check(al, 0);
        wpll(0, 8'h02, 11'h000, 6'h02);
        check(ap, 0);
        wpll(1, 8'hff, 11'h0fe, 6'h03);
        check(bp, 1);
        tog(1, 4100, t);
        check(t >= 510 && t <= 1530, 1);
        check(bl, 1);
    endtask

    task t_osc;
        @(posedge ck);
        im <= 4'h1;
        wosc(1, 8'h02, 0);
        check({eo, st}, 2'b10);
        wait_on(st, 1100);
        check(n >= 955 && n <= 1035, 1);
        cyc(2);
        check(iq, 1);
        check(ss, 0);
        wait_on(dn, 1200);
        check(dn, 1);
        check(ty, 16'd124);
        @(posedge ck);
        im <= 4'h0;
        cyc(2);
        check(iq, 0);
        wosc(0, 8'h00, 1);
        check({eo, st, bo}, 3'b001);
    endtask

    task print_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        {rn, ow, oe, ob, aw, bw, cw, oc, ad, bd, cp, am, bm, as, bs, im} = 0;
        repeat (3) @(posedge ck);
        rn <= 1;
        cyc(4);
        t_reset;
        @(posedge ck);
        cw <= 1; cp <= 8'h5a;
        @(posedge ck);
        cw <= 0;
        cyc(1);
        check(co, 8'h5a);
        t_pll;
        t_osc;
        print_verdict;
    end

    initial begin #300000; errors++; print_verdict; end
endmodule // clock_generator_osc_pll_control_test
